//--- hdl/fbwp_decode.sv
/*
 * Address decoder: maps a CPU address onto flash, loader ROM or nothing.
 * Assumes mode and bank are stable registers of the core.
 */
`include "fbwp_regs.svh"

module fbwp_decode (
    // Request from the core
    fbwp_map_if.decoder map
);
    import fbwp_pkg::*;

    // True when lo <= a <= hi
    function automatic logic in_range(input fbwp_addr_t a,
                                      input fbwp_addr_t lo,
                                      input fbwp_addr_t hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    wire fbwp_addr_t a = map.cpu_addr;
    wire serial = (map.mode == MODE_SERIAL);

    // Window hits
    wire hit_app = in_range(a, `FBWP_FLASH_LO, `FBWP_ADDR_TOP);
    wire hit_rom = in_range(a, `FBWP_ROM_LO, `FBWP_ROM_HI);
    wire hit_up = in_range(a, `FBWP_UPPER_LO, `FBWP_ADDR_TOP);
    wire hit_low = in_range(a, `FBWP_LOWER_LO, `FBWP_ADDR_TOP);

    // Lower bank is folded down by the bank base
    wire fbwp_addr_t low_phys = a - `FBWP_LOWER_SHIFT;

    // Target selection
    assign map.target =
        !serial ? (hit_app ? TGT_FLASH : TGT_NONE) :
        hit_rom ? TGT_ROM :
        map.upper_bank ? (hit_up ? TGT_FLASH : TGT_NONE)
                       : (hit_low ? TGT_FLASH : TGT_NONE);

    // Physical address; bank ignored outside serial mode
    assign map.phys_addr = (serial && !map.upper_bank && !hit_rom) ?
                           low_phys : a;

endmodule

//--- hdl/fbwp_map_if.sv
/*
 * Carrier between the guard core and its address decoder.
 * Assumes both ends run combinationally within one clock.
 */
interface fbwp_map_if;
    import fbwp_pkg::*;

    fbwp_addr_t cpu_addr;
    fbwp_mode_t mode;
    logic upper_bank;
    fbwp_target_t target;
    fbwp_addr_t phys_addr;

    // Core asks, decoder answers
    modport requester (
        output cpu_addr,
        output mode,
        output upper_bank,
        input target,
        input phys_addr
    );
    modport decoder (
        input cpu_addr,
        input mode,
        input upper_bank,
        output target,
        output phys_addr
    );
endinterface

//--- hdl/fbwp_pkg.sv
/*
 * Types of the flash access guard.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fbwp_pkg;

    // Where a CPU access lands
    typedef enum logic [1:0] {
        TGT_NONE,
        TGT_FLASH,
        TGT_ROM
    } fbwp_target_t;

    // Operating mode caught at reset release
    typedef enum logic {
        MODE_APP,
        MODE_SERIAL
    } fbwp_mode_t;

    typedef logic [15:0] fbwp_addr_t;
    typedef logic [7:0] fbwp_byte_t;

endpackage

//--- hdl/fbwp_regs.svh
/*
 * Constants of the flash access guard: register offsets, field positions,
 * reset values and the CPU address windows.
 * Assumes a 16-bit CPU address space and an 8-bit register port.
 */
`ifndef FBWP_REGS_SVH
`define FBWP_REGS_SVH

// Register offsets on the register port
`define FBWP_OFS_FLASH_CONTROL 16'h0fff
`define FBWP_OFS_STATUS 16'h0ffe
`define FBWP_OFS_REFUSED 16'h0ffd

// Flash control register fields
`define FBWP_UNLOCK_MSB 7
`define FBWP_UNLOCK_LSB 4
`define FBWP_BANK_BIT 3
`define FBWP_CODE_ENABLE 4'h3
`define FBWP_CODE_DISABLE 4'hc
`define FBWP_BANK_RESET 1'h1
`define FBWP_LOW_BITS_READ 3'h0

// Status register fields
`define FBWP_ST_UNLOCKED 0
`define FBWP_ST_SERIAL 1
`define FBWP_ST_BANK_LIVE 2
`define FBWP_ST_RESERVED 3
`define FBWP_ST_MISS 4

// CPU address windows
`define FBWP_FLASH_LO 16'h1000
`define FBWP_ROM_LO 16'h7800
`define FBWP_ROM_HI 16'h7fff
`define FBWP_UPPER_LO 16'h8000
`define FBWP_LOWER_LO 16'h9000
`define FBWP_LOWER_SHIFT 16'h8000
`define FBWP_ADDR_TOP 16'hffff

// Refused-command counter
`define FBWP_CNT_MAX 8'hff
`define FBWP_CNT_ONE 8'h01
`define FBWP_CNT_ZERO 8'h00

`endif

//--- hdl/fbwp_top.sv
/*
 * Flash access guard: holds the flash control register, gates flash
 * command writes behind the unlock code, and decodes CPU accesses onto
 * the flash macro in either operating mode and the loader ROM in serial mode.
 * Assumes a flash macro and a loader ROM that return read data in the
 * same cycle as their registered read strobe, a CPU that issues one-cycle
 * strobes, and a mode strap that is steady around reset release.
 */
//
// How it works
// - Flash command writes reach the flash only while the unlock field holds 0011B.
// - Writing 1100B into the unlock field locks the flash against command writes.
// - Reset loads the unlock field with 1100B so commands start out refused.
// - The control register resets to 1100 1xxx: locked and upper bank selected.
// - The three low bits of the control register read as zero.
// - The flash holds 61440 bytes at physical addresses 1000H to FFFFH.
// - In application mode the CPU reaches flash at true addresses and the bank bit is ignored.
// - The bank bit acts only in serial mode, 0 for the lower bank and 1 for the upper.
// - In serial mode a 2-kbyte loader ROM sits at 7800H to 7FFFH instead of flash.
// - In serial mode with the lower bank, 9000H-FFFFH maps to flash 1000H-7FFFH.
// - In serial mode with the upper bank, 8000H-FFFFH maps to flash 8000H-FFFFH.
//
`include "fbwp_regs.svh"

module fbwp_top (
    // Clock, reset and clock enable
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // Mode strap, caught after reset release
    input wire logic i_serial_mode,
    // Register port
    input wire fbwp_pkg::fbwp_addr_t i_reg_addr,
    input wire fbwp_pkg::fbwp_byte_t i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    // CPU flash-space access
    input wire fbwp_pkg::fbwp_addr_t i_cpu_addr,
    input wire fbwp_pkg::fbwp_byte_t i_cpu_wdata,
    input wire logic i_cpu_wr,
    input wire logic i_cpu_rd,
    output logic [7:0] o_cpu_rdata,
    output logic o_cpu_rvalid,
    // Flash macro side
    output logic [15:0] o_flash_addr,
    output logic [7:0] o_flash_wdata,
    output logic o_flash_wr,
    output logic o_flash_rd,
    input wire fbwp_pkg::fbwp_byte_t i_flash_rdata,
    // Loader ROM side
    output logic [15:0] o_rom_addr,
    output logic o_rom_rd,
    input wire fbwp_pkg::fbwp_byte_t i_rom_rdata,
    // Plain status outputs
    output logic o_cmd_enabled,
    output logic o_serial_mode
);
    import fbwp_pkg::*;

    // Overview of the datapath
    //  - The reset synchroniser turns the raw pin into a clean internal
    //    reset whose release always lands just after a clock edge.
    //  - The strap flop catches the operating mode once, so a strap that
    //    moves later cannot remap the flash under running code.
    //  - The control register holds the unlock field and the bank bit.
    //  - The decoder turns a CPU address into a target and a physical
    //    address; it is pure logic and sees only registered mode and bank.
    //  - The memory strobes are registered, so the flash macro and the
    //    loader ROM see clean one-cycle pulses with a settled address.
    //  - Read data are taken from the macro while its strobe stands and
    //    handed to the CPU one cycle later with a valid pulse.
    //  - Status flags and the refusal counter give software a view of
    //    what the guard swallowed.
    //
    // Hazards kept in mind
    //  - A write to the control register and a command write in the same
    //    cycle use the old unlock value; the new code acts one cycle on.
    //  - Reserved codes are kept as written so software can read back its
    //    own mistake, but they never open the command path.
    //  - The bank bit is stored in either mode; only the decoder decides
    //    whether it matters, which keeps the register plain read-write.
    //  - Clock enable low freezes every register but the synchroniser,
    //    so a reset still completes while the core clock is gated.

    // Reset synchroniser: the first stage feeds only the second
    logic [1:0] rst_sync_q;
    wire rst_n = rst_sync_q[1];

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'h1};
        end
    end

    // Mode strap capture: taken once on the first enabled cycle after
    // release, so the async reset only ever loads constants
    logic strap_done_q;
    fbwp_mode_t mode_q;

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            strap_done_q <= 1'h0;
            mode_q <= MODE_APP;
        end else if (i_ce && !strap_done_q) begin
            strap_done_q <= 1'h1;
            mode_q <= i_serial_mode ? MODE_SERIAL : MODE_APP;
        end
    end

    wire serial = (mode_q == MODE_SERIAL);

    // Register port address decode
    wire sel_ctrl = (i_reg_addr == `FBWP_OFS_FLASH_CONTROL);
    wire sel_stat = (i_reg_addr == `FBWP_OFS_STATUS);
    wire sel_cnt = (i_reg_addr == `FBWP_OFS_REFUSED);
    wire wr_ctrl = i_reg_wr && sel_ctrl;
    wire wr_stat = i_reg_wr && sel_stat;
    wire wr_cnt = i_reg_wr && sel_cnt;

    // Incoming unlock field and bank bit
    wire [3:0] new_code = i_reg_wdata[`FBWP_UNLOCK_MSB:`FBWP_UNLOCK_LSB];
    wire new_bank = i_reg_wdata[`FBWP_BANK_BIT];
    // A code that is neither the enabling nor the disabling one
    wire code_reserved = (new_code != `FBWP_CODE_ENABLE) &&
                         (new_code != `FBWP_CODE_DISABLE);

    // Flash control register: unlock field and bank bit
    logic [3:0] unlock_q;
    logic bank_q;
    logic [3:0] unlock_d;
    logic bank_d;

    assign unlock_d = wr_ctrl ? new_code : unlock_q;
    assign bank_d = wr_ctrl ? new_bank : bank_q;

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            unlock_q <= `FBWP_CODE_DISABLE;
            bank_q <= `FBWP_BANK_RESET;
        end else if (i_ce) begin
            unlock_q <= unlock_d;
            bank_q <= bank_d;
        end
    end

    // Only the exact enabling code opens the command path; reserved codes
    // are stored and read back but keep the flash locked
    wire cmd_enabled = (unlock_q == `FBWP_CODE_ENABLE);

    // CPU address decode through the mapping carrier
    fbwp_map_if map ();

    assign map.cpu_addr = i_cpu_addr;
    assign map.mode = mode_q;
    assign map.upper_bank = bank_q;

    fbwp_decode u_decode (
        .map(map)
    );

    // Access classification; nothing is issued before the strap is caught
    wire live = strap_done_q;
    wire to_flash = live && (map.target == TGT_FLASH);
    wire to_rom = live && (map.target == TGT_ROM);
    wire any_req = live && (i_cpu_wr || i_cpu_rd);
    wire miss = any_req && (map.target == TGT_NONE);

    // Command writes pass only when unlocked; the loader ROM is read-only
    wire flash_wr_ok = i_cpu_wr && to_flash && cmd_enabled;
    wire flash_rd_go = i_cpu_rd && to_flash;
    wire rom_rd_go = i_cpu_rd && to_rom;
    // A command write swallowed by the lock
    wire cmd_refused = i_cpu_wr && to_flash && !cmd_enabled;

    // Flash and ROM strobes and addresses, registered
    logic [15:0] flash_addr_q;
    logic [7:0] flash_wdata_q;
    logic flash_wr_q;
    logic flash_rd_q;
    logic [15:0] rom_addr_q;
    logic rom_rd_q;

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            flash_addr_q <= 16'h0000;
            flash_wdata_q <= 8'h00;
            flash_wr_q <= 1'h0;
            flash_rd_q <= 1'h0;
            rom_addr_q <= 16'h0000;
            rom_rd_q <= 1'h0;
        end else if (i_ce) begin
            flash_wr_q <= flash_wr_ok;
            flash_rd_q <= flash_rd_go;
            rom_rd_q <= rom_rd_go;
            if (flash_wr_ok || flash_rd_go) begin
                flash_addr_q <= map.phys_addr;
                flash_wdata_q <= i_cpu_wdata;
            end
            if (rom_rd_go) begin
                rom_addr_q <= map.phys_addr;
            end
        end
    end

    // The macros answer while their strobe stands; the data are caught
    // here on the edge that ends the strobe, which keeps the CPU side
    // free of any path through the macro.
    // Only one of the two strobes can be high in a cycle because the
    // decoder gives each address exactly one target.
    // Read return: one cycle after the macro strobe
    logic [7:0] cpu_rdata_q;
    logic cpu_rvalid_q;
    wire ret_any = flash_rd_q || rom_rd_q;
    wire [7:0] ret_data = rom_rd_q ? i_rom_rdata : i_flash_rdata;

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_rdata_q <= 8'h00;
            cpu_rvalid_q <= 1'h0;
        end else if (i_ce) begin
            cpu_rvalid_q <= ret_any;
            if (ret_any) begin
                cpu_rdata_q <= ret_data;
            end
        end
    end

    // Sticky reserved-code flag; a new event wins over a clear
    logic reserved_q;
    wire reserved_clr = wr_stat && i_reg_wdata[`FBWP_ST_RESERVED];
    wire reserved_set = wr_ctrl && code_reserved;

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            reserved_q <= 1'h0;
        end else if (i_ce) begin
            if (reserved_set) begin
                reserved_q <= 1'h1;
            end else if (reserved_clr) begin
                reserved_q <= 1'h0;
            end
        end
    end

    // Sticky unmapped-access flag; a new miss wins over a clear
    logic miss_q;
    wire miss_clr = wr_stat && i_reg_wdata[`FBWP_ST_MISS];

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            miss_q <= 1'h0;
        end else if (i_ce) begin
            if (miss) begin
                miss_q <= 1'h1;
            end else if (miss_clr) begin
                miss_q <= 1'h0;
            end
        end
    end

    // The count lets software tell after the fact that a command sequence
    // was tried with the lock closed; a wrapped count would hide that,
    // hence the saturation.
    // Saturating count of refused command writes; any write clears it,
    // but a refusal in the same cycle leaves a count of one
    logic [7:0] refused_q;
    logic [7:0] refused_d;
    wire cnt_full = (refused_q == `FBWP_CNT_MAX);

    assign refused_d =
        (wr_cnt && cmd_refused) ? `FBWP_CNT_ONE :
        wr_cnt ? `FBWP_CNT_ZERO :
        (cmd_refused && !cnt_full) ? refused_q + `FBWP_CNT_ONE :
        refused_q;

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            refused_q <= `FBWP_CNT_ZERO;
        end else if (i_ce) begin
            refused_q <= refused_d;
        end
    end

    // Register map as software sees it
    //  - Control: unlock field in the top nibble, bank bit below it,
    //    and the three low bits always read as zero.
    //  - Status: unlocked, serial mode, live bank, reserved-code flag
    //    and unmapped-access flag, from bit 0 upwards.
    //  - Refused count: number of command writes swallowed by the lock,
    //    stopping at its top value instead of wrapping.
    // Reads of any other offset return zero and writes there are lost.
    // The read data register clears itself in the cycle after a read,
    // so a stale value never looks like a fresh answer.
    //
    // Read views of the registers
    wire [7:0] ctrl_view = {unlock_q, bank_q, `FBWP_LOW_BITS_READ};
    logic [7:0] stat_view;

    always_comb begin
        stat_view = 8'h00;
        stat_view[`FBWP_ST_UNLOCKED] = cmd_enabled;
        stat_view[`FBWP_ST_SERIAL] = serial;
        stat_view[`FBWP_ST_BANK_LIVE] = serial && bank_q;
        stat_view[`FBWP_ST_RESERVED] = reserved_q;
        stat_view[`FBWP_ST_MISS] = miss_q;
    end

    // Read mux; unmapped offsets read zero
    wire [7:0] rd_mux = sel_ctrl ? ctrl_view :
                        sel_stat ? stat_view :
                        sel_cnt ? refused_q :
                        8'h00;

    // Read data stand only in the cycle after the strobe
    logic [7:0] reg_rdata_q;

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= 8'h00;
        end else if (i_ce) begin
            reg_rdata_q <= i_reg_rd ? rd_mux : 8'h00;
        end
    end

    // Outputs
    assign o_reg_rdata = reg_rdata_q;
    assign o_cpu_rdata = cpu_rdata_q;
    assign o_cpu_rvalid = cpu_rvalid_q;
    assign o_flash_addr = flash_addr_q;
    assign o_flash_wdata = flash_wdata_q;
    assign o_flash_wr = flash_wr_q;
    assign o_flash_rd = flash_rd_q;
    assign o_rom_addr = rom_addr_q;
    assign o_rom_rd = rom_rd_q;
    assign o_cmd_enabled = cmd_enabled;
    assign o_serial_mode = serial;

endmodule

//--- sim/fbwp_mem_model.sv
/*
 * Behavioural flash macro and loader ROM behind the access guard.
 * Assumes one-cycle read strobes taken on the rising clock edge.
 */
module fbwp_mem_model (
    // Clock
    input wire logic i_mclk,
    // Read requests from the guard
    input wire logic [15:0] i_flash_addr,
    input wire logic i_flash_rd,
    input wire logic [15:0] i_rom_addr,
    input wire logic i_rom_rd,
    // Read data, standing while the strobe stands
    output logic [7:0] o_flash_rdata,
    output logic [7:0] o_rom_rdata
);
    // Filler that toggles every cycle so a late sample never matches
    logic [7:0] tog = 8'h5a;

    always @(posedge i_mclk) begin
        tog <= ~tog;
    end

    // Data is a hash of the address while the guard's strobe is high and, for flash, the address is 1000H or above
    assign o_flash_rdata = (i_flash_rd && i_flash_addr >= 16'h1000) ?
        (i_flash_addr[7:0] ^ i_flash_addr[15:8]) : tog;
    assign o_rom_rdata = i_rom_rd ? ~i_rom_addr[7:0] : ~tog;
endmodule

//--- sim/fbwp_tb.sv
/*
 * Self-checking bench of the flash access guard.
 * Assumes the memory model answers reads in the same cycle, while the strobe stands.
 */
`include "fbwp_regs.svh"
module fbwp_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fbwp_pkg::*;
    localparam fbwp_addr_t CTL = `FBWP_OFS_FLASH_CONTROL;
    localparam logic [2:0] NO = 3'b000, WF = 3'b100, RF = 3'b010, RR = 3'b001;
    logic i_mclk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_serial_mode = 1'b0;
    fbwp_addr_t i_reg_addr = 16'h0, i_cpu_addr = 16'h0;
    fbwp_byte_t i_reg_wdata = 8'h0, i_cpu_wdata = 8'h0;
    logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_cpu_wr = 1'b0, i_cpu_rd = 1'b0;
    logic [7:0] o_reg_rdata, o_cpu_rdata, o_flash_wdata;
    logic [15:0] o_flash_addr, o_rom_addr;
    logic o_cpu_rvalid, o_flash_wr, o_flash_rd, o_rom_rd;
    logic o_cmd_enabled, o_serial_mode;
    fbwp_byte_t i_flash_rdata, i_rom_rdata;
    int n_errors = 0, num_checks = 0;

    // 125 MHz clock
    always #4 i_mclk = ~i_mclk;

    fbwp_top dut (.i_mclk, .i_rst_n, .i_ce, .i_serial_mode, .i_reg_addr,
        .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_cpu_addr,
        .i_cpu_wdata, .i_cpu_wr, .i_cpu_rd, .o_cpu_rdata, .o_cpu_rvalid,
        .o_flash_addr, .o_flash_wdata, .o_flash_wr, .o_flash_rd, .i_flash_rdata,
        .o_rom_addr, .o_rom_rd, .i_rom_rdata, .o_cmd_enabled, .o_serial_mode);
    fbwp_mem_model u_mem (.i_mclk, .i_flash_addr(o_flash_addr),
        .i_flash_rd(o_flash_rd), .i_rom_addr(o_rom_addr), .i_rom_rd(o_rom_rd),
        .o_flash_rdata(i_flash_rdata), .o_rom_rdata(i_rom_rdata));

    function automatic fbwp_byte_t fx(input fbwp_addr_t a);
        return a[7:0] ^ a[15:8];
    endfunction

    task automatic chk(input string nm, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic print_verdict;
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Reset held 8 cycles, then wait until CPU requests are honoured
    task automatic rst(input logic ser);
        i_rst_n <= 1'b0;
        i_serial_mode <= ser;
        repeat (8) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_mclk);
    endtask

    task automatic reg_wr(input fbwp_addr_t a, input fbwp_byte_t d);
        @(posedge i_mclk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
    endtask

    task automatic reg_rd(input fbwp_addr_t a, input fbwp_byte_t e);
        @(posedge i_mclk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_mclk);
        i_reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", {8'h0, e}, {8'h0, o_reg_rdata});
    endtask

    // One CPU access; es lists expected flash write, flash read, ROM read
    task automatic cpu(input logic wr, input fbwp_addr_t a, input logic [2:0] es,
            input fbwp_addr_t ea);
        @(posedge i_mclk);
        i_cpu_wr <= wr;
        i_cpu_rd <= !wr;
        i_cpu_addr <= a;
        i_cpu_wdata <= ~a[7:0];
        @(posedge i_mclk);
        i_cpu_wr <= 1'b0;
        i_cpu_rd <= 1'b0;
        #1;
        chk("strobes", {13'h0, es}, {13'h0, o_flash_wr, o_flash_rd, o_rom_rd});
        if (es[2:1] != 2'h0) chk("flash_addr", ea, o_flash_addr);
        if (es[0]) chk("rom_addr", ea, o_rom_addr);
        if (es[2]) chk("flash_wdata", {8'h0, ~a[7:0]}, {8'h0, o_flash_wdata});
        @(posedge i_mclk);
        #1;
        chk("rvalid", {15'h0, |es[1:0]}, {15'h0, o_cpu_rvalid});
        if (es[1]) chk("cpu_rdata", {8'h0, fx(ea)}, {8'h0, o_cpu_rdata});
        if (es[0]) chk("cpu_rdata", {8'h0, ~ea[7:0]}, {8'h0, o_cpu_rdata});
    endtask

    // Watchdog
    initial begin
        #40000;
        n_errors++;
        print_verdict;
    end

    initial begin
        rst(1'b0);
        reg_rd(CTL, 8'hc8);
        chk("cmd_en", 16'h0, {15'h0, o_cmd_enabled});
        cpu(1'b1, 16'h1234, NO, 16'h0);
        reg_wr(CTL, 8'h30);
        reg_rd(CTL, 8'h30);
        chk("cmd_en", 16'h1, {15'h0, o_cmd_enabled});
        cpu(1'b1, 16'h1234, WF, 16'h1234);
        reg_wr(CTL, 8'h50);
        reg_rd(16'h0ffe, 8'h08);
        cpu(1'b1, 16'h2000, NO, 16'h0);
        reg_wr(CTL, 8'hc0);
        cpu(1'b1, 16'hf000, NO, 16'h0);
        @(posedge i_mclk);
        i_ce <= 1'b0;
        reg_wr(CTL, 8'h30);
        i_ce <= 1'b1;
        reg_rd(CTL, 8'hc0);
        reg_rd(`FBWP_OFS_REFUSED, 8'h03);
        cpu(1'b0, 16'hf000, RF, 16'hf000);
        cpu(1'b0, 16'h1000, RF, 16'h1000);
        cpu(1'b0, 16'hffff, RF, 16'hffff);
        cpu(1'b0, 16'h0fff, NO, 16'h0);
        reg_rd(16'h0ffe, 8'h18);
        reg_wr(16'h0ffe, 8'h18);
        reg_rd(16'h0ffe, 8'h00);
        reg_rd(16'h0ffc, 8'h00);
        rst(1'b1);
        reg_rd(CTL, 8'hc8);
        chk("serial", 16'h1, {15'h0, o_serial_mode});
        reg_rd(16'h0ffe, 8'h06);
        cpu(1'b0, 16'h7800, RR, 16'h7800);
        cpu(1'b0, 16'h7fff, RR, 16'h7fff);
        cpu(1'b0, 16'h8000, RF, 16'h8000);
        cpu(1'b0, 16'h9000, RF, 16'h9000);
        reg_wr(CTL, 8'h30);
        reg_rd(16'h0ffe, 8'h03);
        cpu(1'b0, 16'h9000, RF, 16'h1000);
        cpu(1'b0, 16'hffff, RF, 16'h7fff);
        cpu(1'b0, 16'h8fff, NO, 16'h0);
        cpu(1'b0, 16'h1000, NO, 16'h0);
        cpu(1'b1, 16'hf000, WF, 16'h7000);
        reg_wr(CTL, 8'hc8);
        print_verdict;
    end
endmodule

//--- sim/fbwp_top_chk.sv
/*
 * Port checker of the flash access guard.
 * Assumes one clock domain and a bind onto fbwp_top.
 */
`include "fbwp_regs.svh"
module fbwp_top_chk (
    // Clock, reset and enable
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // Register port
    input wire fbwp_pkg::fbwp_addr_t i_reg_addr,
    input wire fbwp_pkg::fbwp_byte_t i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    // CPU and memory sides
    input wire fbwp_pkg::fbwp_addr_t i_cpu_addr,
    input wire logic i_cpu_rd,
    input wire logic [15:0] o_flash_addr,
    input wire logic o_flash_wr,
    input wire logic o_flash_rd,
    input wire logic [15:0] o_rom_addr,
    input wire logic o_rom_rd,
    input wire logic o_cmd_enabled,
    input wire logic o_serial_mode
);
    import fbwp_pkg::*;
    logic [3:0] unl_q;
    logic bank_q;
    logic [1:0] up_q;
    wire ctl_wr = i_ce && i_reg_wr && i_reg_addr == `FBWP_OFS_FLASH_CONTROL;
    wire ctl_rd = i_ce && i_reg_rd && i_reg_addr == `FBWP_OFS_FLASH_CONTROL;
    wire cpu_rq = i_ce && i_cpu_rd && up_q == 2'h3;
    wire ser = o_serial_mode;

    // Shadow of the control register and edges since reset release
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            unl_q <= `FBWP_CODE_DISABLE;
            bank_q <= `FBWP_BANK_RESET;
            up_q <= 2'h0;
        end else begin
            if (ctl_wr) begin
                unl_q <= i_reg_wdata[7:4];
                bank_q <= i_reg_wdata[3];
            end
            if (i_ce && up_q != 2'h3) begin
                up_q <= up_q + 2'h1;
            end
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    AST_RST_LOCK: assert property (disable iff (1'b0)
        !i_rst_n |-> !o_cmd_enabled) else $error("enabled in reset");
    AST_CMD_LEVEL: assert property (
        o_cmd_enabled == (unl_q == `FBWP_CODE_ENABLE))
        else $error("enable level wrong");
    AST_LOCK: assert property (
        ctl_wr && i_reg_wdata[7:4] == `FBWP_CODE_DISABLE |=> !o_cmd_enabled)
        else $error("lock code ignored");
    AST_WR_GATE: assert property (
        o_flash_wr |-> $past(o_cmd_enabled)) else $error("write not gated");
    AST_CTL_READ: assert property (
        ctl_rd |=> o_reg_rdata[7:3] == $past({unl_q, bank_q}))
        else $error("control read wrong");
    AST_APP_MAP: assert property (
        cpu_rq && !ser && i_cpu_addr >= `FBWP_FLASH_LO
        |=> o_flash_rd && o_flash_addr == $past(i_cpu_addr))
        else $error("app map wrong");
    AST_ROM: assert property (
        cpu_rq && ser && i_cpu_addr inside {[`FBWP_ROM_LO:`FBWP_ROM_HI]}
        |=> o_rom_rd && !o_flash_rd && o_rom_addr == $past(i_cpu_addr))
        else $error("rom map wrong");
    AST_LOWER: assert property (
        cpu_rq && ser && !bank_q && i_cpu_addr >= `FBWP_LOWER_LO
        |=> o_flash_rd && o_flash_addr == $past(i_cpu_addr) - 16'h8000)
        else $error("lower bank map wrong");
    AST_UPPER: assert property (
        cpu_rq && ser && bank_q && i_cpu_addr >= `FBWP_UPPER_LO
        |=> o_flash_rd && o_flash_addr == $past(i_cpu_addr))
        else $error("upper bank map wrong");
    AST_GAP: assert property (
        cpu_rq && ser && !bank_q && i_cpu_addr inside {[16'h8000:16'h8fff]}
        |=> !o_flash_rd) else $error("lower bank gap mapped");

    // Main scenarios reached
    COV_LOWER: cover property (cpu_rq && ser && !bank_q);
    COV_ROM: cover property (o_rom_rd);
    COV_WR: cover property (o_flash_wr);
endmodule

bind fbwp_top fbwp_top_chk u_chk (.i_mclk, .i_rst_n, .i_ce, .i_reg_addr,
    .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_cpu_addr, .i_cpu_rd,
    .o_flash_addr, .o_flash_wr, .o_flash_rd, .o_rom_addr, .o_rom_rd,
    .o_cmd_enabled, .o_serial_mode);
